// File: hw/cradle_position_monitor.sv
/*
  cradle position monitor: decodes three contacts, counts entries, logs
  contact-change events and latches maintenance alarms.
  assumes a calendar time base (seconds stamp plus a one-cycle month tick),
  an external non-volatile store that restores counters at power-up through
  the load port and saves them from the counter outputs, and a trip unit
  serial number presented with a strobe.
*/
`timescale 1ns/1ns
`include "cradle_monitor_regs.svh"

module cradle_position_monitor (
  input wire logic clock_i, // 25 MHz system clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire cradle_monitor_pkg::contacts_s contacts_i, // raw contact inputs
  input wire logic [31:0] time_stamp_i, // calendar time now
  input wire logic month_tick_i, // one pulse per calendar month
  input wire logic nv_load_i, // restore counters from storage
  input wire cradle_monitor_pkg::counters_s nv_counters_i, // stored counter values
  input wire logic serial_valid_i, // trip unit serial strobe
  input wire logic [31:0] serial_i, // trip unit serial number
  input wire logic local_reset_i, // manual alarm reset pulse
  input wire logic remote_reset_i, // remote alarm reset pulse
  output cradle_monitor_pkg::position_e position_o, // decoded position
  output cradle_monitor_pkg::counters_s counters_o, // counters for storage
  output logic nv_save_o, // counters changed, save them
  output cradle_monitor_pkg::stamps_s stamps_o, // last entry times
  output cradle_monitor_pkg::event_s event_o, // event/alarm log entry
  output cradle_monitor_pkg::alarms_s alarms_o, // latched alarms
  output logic [31:0] trip_unit_stamp_o // time of trip unit change
);
  import cradle_monitor_pkg::*;

  // input synchroniser
  contacts_s sync1, sync2, prev;
  contacts_s next_sync1, next_sync2, next_prev;

  always_comb begin
    next_sync1 = contacts_i;
    next_sync2 = sync1;
    next_prev = sync2;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sync1 <= '1;
      sync2 <= '1;
      prev <= '1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  // warm-up: reset ones in the synchroniser are not a contact sample
  logic [2:0] fill, next_fill;
  logic primed, settled;
  contacts_s changed;

  always_comb begin
    next_fill = {fill[1:0], 1'b1};
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  // sync2 real after two edges, prev after three
  assign primed = fill[1];
  assign settled = fill[2];
  assign changed = settled ? contacts_s'(sync2 ^ prev) : '0;

  // decode
  // a cradle without test contact never decodes test
  position_e decoded;
  always_comb begin
    case ({sync2.connected_contact_in, sync2.disconnected_contact_in, sync2.test_contact_in})
      3'b011: decoded = POS_CONNECTED;
      3'b101: decoded = POS_DISCONNECTED;
      3'b110: decoded = POS_TEST;
      default: decoded = POS_NONE;
    endcase
  end

  // position and counters
  // nv_load_i wins over an entry in the same cycle
  // leaving a discrepancy for a position counts as an entry
  position_e position;
  position_e next_position;
  counters_s counters, next_counters;
  stamps_s stamps, next_stamps;
  logic nv_save, next_nv_save;
  logic entered;

  function automatic logic [15:0] bump(input logic [15:0] value);
    if (value >= `COUNT_MAX) begin
      bump = value;
    end else begin
      bump = value + 16'h0001;
    end
  endfunction

  assign entered = (decoded != position) && (decoded != POS_NONE);

  always_comb begin
    next_position = decoded;
    next_counters = counters;
    next_stamps = stamps;
    next_nv_save = 1'b0;
    if (nv_load_i) begin
      next_counters = nv_counters_i;
    end else if (entered) begin
      next_nv_save = 1'b1;
      case (decoded)
        POS_CONNECTED: begin
          next_counters.connected = bump(counters.connected);
          next_stamps.last_connection = time_stamp_i;
        end
        POS_DISCONNECTED: begin
          next_counters.disconnected = bump(counters.disconnected);
          next_stamps.last_disconnection = time_stamp_i;
        end
        POS_TEST: begin
          next_counters.test = bump(counters.test);
          next_stamps.last_test = time_stamp_i;
        end
        default: begin
          next_nv_save = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      position <= POS_NONE;
      counters <= {`COUNT_RESET, `COUNT_RESET, `COUNT_RESET};
      stamps <= '0;
      nv_save <= 1'b0;
    end else begin
      position <= next_position;
      counters <= next_counters;
      stamps <= next_stamps;
      nv_save <= next_nv_save;
    end
  end

  // calendar timers
  // both timers stop at their limit so they cannot wrap
  logic [31:0] overdue_months, service_months;
  logic [31:0] next_overdue_months, next_service_months;

  always_comb begin
    next_overdue_months = overdue_months;
    next_service_months = service_months;
    if (entered && decoded == POS_DISCONNECTED) begin
      next_overdue_months = '0;
    end else if (month_tick_i && overdue_months < `OVERDUE_MONTHS) begin
      next_overdue_months = overdue_months + 32'h0000_0001;
    end
    if (month_tick_i && service_months < `SERVICE_MONTHS) begin
      next_service_months = service_months + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      overdue_months <= '0;
      service_months <= '0;
    end else begin
      overdue_months <= next_overdue_months;
      service_months <= next_service_months;
    end
  end

  // trip unit serial tracking
  // the first strobe after reset only records the serial
  logic [31:0] serial_seen, next_serial_seen;
  logic serial_known, next_serial_known;
  logic [31:0] trip_stamp, next_trip_stamp;
  logic serial_changed;

  assign serial_changed = serial_valid_i && serial_known && (serial_i != serial_seen);

  always_comb begin
    next_serial_seen = serial_seen;
    next_serial_known = serial_known;
    next_trip_stamp = trip_stamp;
    if (serial_valid_i) begin
      next_serial_seen = serial_i;
      next_serial_known = 1'b1;
    end
    if (serial_changed) begin
      next_trip_stamp = time_stamp_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      serial_seen <= '0;
      serial_known <= 1'b0;
      trip_stamp <= '0;
    end else begin
      serial_seen <= next_serial_seen;
      serial_known <= next_serial_known;
      trip_stamp <= next_trip_stamp;
    end
  end

  // latched alarms, set wins over clear
  // a clear while the cause persists leaves the alarm set
  alarms_s alarms, next_alarms, alarm_set, alarm_rise;
  logic alarm_clear;

  always_comb begin
    alarm_set.discrepancy = primed && (decoded == POS_NONE);
    alarm_set.overdue = (overdue_months >= `OVERDUE_MONTHS);
    alarm_set.max_ops = (counters.connected >= `MAX_OPS_LIMIT);
    alarm_set.service_life = (service_months >= `SERVICE_MONTHS) ||
                             (counters.connected >= `SERVICE_OPS_LIMIT);
    alarm_set.new_trip_unit = serial_changed;
    alarm_clear = local_reset_i || remote_reset_i;
    next_alarms = alarm_clear ? alarm_set : (alarms | alarm_set);
    alarm_rise = alarm_set & ~alarms;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      alarms <= '0;
    end else begin
      alarms <= next_alarms;
    end
  end

  // event log entry: alarms by priority, then contact changes
  // one entry a cycle; a cause beaten in the same cycle is not logged
  event_s log_entry, next_log_entry;

  always_comb begin
    next_log_entry.valid = 1'b1;
    next_log_entry.stamp = time_stamp_i;
    next_log_entry.code = '0;
    if (alarm_rise.new_trip_unit) begin
      next_log_entry.code = `CODE_NEW_TRIP_UNIT;
    end else if (alarm_rise.max_ops) begin
      next_log_entry.code = `CODE_MAX_OPS;
    end else if (alarm_rise.discrepancy) begin
      next_log_entry.code = `CODE_DISCREPANCY;
    end else if (alarm_rise.overdue) begin
      next_log_entry.code = `CODE_OVERDUE;
    end else if (alarm_rise.service_life) begin
      next_log_entry.code = `CODE_SERVICE_LIFE;
    end else if (changed.connected_contact_in) begin
      next_log_entry.code = `CODE_CONN_CHANGE;
    end else if (changed.disconnected_contact_in) begin
      next_log_entry.code = `CODE_DISC_CHANGE;
    end else if (changed.test_contact_in) begin
      next_log_entry.code = `CODE_TEST_CHANGE;
    end else begin
      next_log_entry.valid = 1'b0;
      next_log_entry.stamp = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      log_entry <= '0;
    end else begin
      log_entry <= next_log_entry;
    end
  end

  // every output straight from a register
  assign position_o = position;
  assign counters_o = counters;
  assign nv_save_o = nv_save;
  assign stamps_o = stamps;
  assign event_o = log_entry;
  assign alarms_o = alarms;
  assign trip_unit_stamp_o = trip_stamp;
endmodule

// File: hw/cradle_monitor_regs.svh
/*
  constants for the cradle position monitor: event codes, counter limits, time spans.
  assumes inclusion by bare name from the design file, the checker and the bench.
*/
`ifndef CRADLE_MONITOR_REGS_SVH
`define CRADLE_MONITOR_REGS_SVH

`define CODE_DISCREPANCY 16'h0900
`define CODE_CONN_CHANGE 16'h0901
`define CODE_DISC_CHANGE 16'h0902
`define CODE_TEST_CHANGE 16'h0903
`define CODE_OVERDUE 16'h0904
`define CODE_MAX_OPS 16'h0905
`define CODE_SERVICE_LIFE 16'h0906
`define CODE_NEW_TRIP_UNIT 16'h0907

`define COUNT_MAX 16'hFFFE
`define COUNT_RESET 16'h0000
`define MAX_OPS_LIMIT 16'h01C2
`define SERVICE_OPS_LIMIT 16'h00FA

`define OVERDUE_MONTHS 32'h0000_000B
`define SERVICE_YEARS 32'h0000_0005
`define MONTHS_PER_YEAR 32'h0000_000C
`define SERVICE_MONTHS (`SERVICE_YEARS * `MONTHS_PER_YEAR)

`endif

// File: hw/cradle_monitor_pkg.sv
/*
  types shared by the cradle position monitor and its bench.
  assumes cradle_monitor_regs.svh is on the include path.
*/
package cradle_monitor_pkg;
  typedef enum logic [3:0] {
    POS_NONE = 4'b0001,
    POS_CONNECTED = 4'b0010,
    POS_DISCONNECTED = 4'b0100,
    POS_TEST = 4'b1000
  } position_e;

  typedef struct packed {
    logic connected_contact_in;
    logic disconnected_contact_in;
    logic test_contact_in;
  } contacts_s;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic [31:0] stamp;
  } event_s;

  typedef struct packed {
    logic discrepancy;
    logic overdue;
    logic max_ops;
    logic service_life;
    logic new_trip_unit;
  } alarms_s;

  typedef struct packed {
    logic [15:0] connected;
    logic [15:0] disconnected;
    logic [15:0] test;
  } counters_s;

  typedef struct packed {
    logic [31:0] last_connection;
    logic [31:0] last_disconnection;
    logic [31:0] last_test;
  } stamps_s;
endpackage

// File: verif/cradle_monitor_assertions.sv
/* checker for the cradle position monitor ports.
   assumes a bind from the bench and a stable time stamp around entries. */
`timescale 1ns/1ns
`include "cradle_monitor_regs.svh"
module cradle_monitor_assertions (
  input wire logic clock_i, // clock
  input wire logic nrst_i, // reset, active low
  input wire cradle_monitor_pkg::contacts_s contacts_i, // contacts
  input wire logic [31:0] time_stamp_i, // calendar time
  input wire logic nv_load_i, // counter restore
  input wire logic serial_valid_i, // serial strobe
  input wire logic local_reset_i, // local clear
  input wire logic remote_reset_i, // remote clear
  input wire cradle_monitor_pkg::position_e position_o, // position
  input wire cradle_monitor_pkg::counters_s counters_o, // counters
  input wire logic nv_save_o, // save strobe
  input wire cradle_monitor_pkg::stamps_s stamps_o, // entry times
  input wire cradle_monitor_pkg::event_s event_o, // log entry
  input wire cradle_monitor_pkg::alarms_s alarms_o, // alarms
  input wire logic [31:0] trip_unit_stamp_o // trip unit time
);
  import cradle_monitor_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  chk_conn_decode: assert property ((contacts_i == 3'b011) [*4] |-> position_o == POS_CONNECTED)
    else $error("connected not decoded");
  chk_disc_decode: assert property ((contacts_i == 3'b101) [*4] |-> position_o == POS_DISCONNECTED)
    else $error("disconnected not decoded");
  chk_test_decode: assert property ((contacts_i == 3'b110) [*4] |-> position_o == POS_TEST)
    else $error("test not decoded");
  chk_bad_pattern: assert property ((!(contacts_i inside {3'b011, 3'b101, 3'b110})) [*5]
    |-> position_o == POS_NONE && alarms_o.discrepancy) else $error("bad pattern not flagged");
  chk_count_step: assert property (!$past(nv_load_i) && $changed(counters_o.connected)
    |-> counters_o.connected == $past(counters_o.connected) + 16'h0001) else $error("counter jump");
  chk_save_pulse: assert property (!$past(nv_load_i) && $changed(counters_o) |-> nv_save_o)
    else $error("counter change not saved");
  chk_count_ceiling: assert property (counters_o.connected <= `COUNT_MAX)
    else $error("counter above ceiling");
  chk_conn_stamp: assert property ($changed(position_o) && position_o == POS_CONNECTED
    |-> stamps_o.last_connection == $past(time_stamp_i)) else $error("connection stamp wrong");
  chk_max_ops_alarm: assert property ($rose(counters_o.connected == `MAX_OPS_LIMIT)
    |=> alarms_o.max_ops && event_o.valid && event_o.code == `CODE_MAX_OPS) else $error("max ops late");
  chk_alarm_hold: assert property ((($past(alarms_o) & ~alarms_o) != 0)
    |-> $past(local_reset_i || remote_reset_i)) else $error("alarm dropped alone");
  chk_trip_alarm: assert property ($rose(alarms_o.new_trip_unit) |-> $past(serial_valid_i) &&
    event_o.code == `CODE_NEW_TRIP_UNIT && trip_unit_stamp_o == $past(time_stamp_i)) else $error("trip alarm");
endmodule

// File: verif/cradle_contacts_model.sv
/* cradle auxiliary contacts: a position command becomes three contacts.
   assumes the command changes at the falling edge. */
`timescale 1ns/1ns
module cradle_contacts_model (
  input wire logic clock_i, // clock
  input wire logic [1:0] cmd_i, // 0 conn, 1 disc, 2 test, 3 travel
  input wire logic no_test_i, // cradle without test contact
  output cradle_monitor_pkg::contacts_s contacts_o // contacts, low = made
);
  import cradle_monitor_pkg::*;
  always @(negedge clock_i) begin
    contacts_o <= {cmd_i != 2'd0, cmd_i != 2'd1, cmd_i != 2'd2 || no_test_i};
  end
endmodule

// File: verif/test_cradle_position_monitor.sv
/* self-checking bench for the cradle position monitor.
   assumes the contacts model and the checker are compiled before it. */
`timescale 1ns/1ns
`include "cradle_monitor_regs.svh"
module test_cradle_position_monitor;
  import cradle_monitor_pkg::*;
  logic clock_i = 0, nrst_i = 0, month_tick_i = 0, nv_load_i = 0, serial_valid_i = 0;
  logic local_reset_i = 0, remote_reset_i = 0, no_test = 0, bad = 0, armed = 0, nv_save_o;
  logic [1:0] cmd = 2'd1;
  logic [31:0] time_stamp_i = 32'h0000_1000, serial_i = 0, trip_unit_stamp_o, sn;
  counters_s nv_counters_i = '0, counters_o;
  contacts_s contacts_i;
  position_e position_o;
  stamps_s stamps_o;
  event_s event_o;
  alarms_s alarms_o, ea = '0;
  logic [47:0] q[$];
  logic [15:0] cnt[3] = '{16'h0000, 16'h0001, 16'h0000};
  logic [31:0] st[3] = '{32'h0000_0000, 32'h0000_1000, 32'h0000_0000};
  logic [2:0] prev = 3'b101;
  int errors = 0, checked = 0;
  always #20 clock_i = ~clock_i;
  cradle_contacts_model u_cradle_contacts_model (.clock_i, .cmd_i(cmd), .no_test_i(no_test), .contacts_o(contacts_i));
  cradle_position_monitor u_cradle_position_monitor (.clock_i, .nrst_i, .contacts_i, .time_stamp_i, .month_tick_i,
    .nv_load_i, .nv_counters_i, .serial_valid_i, .serial_i, .local_reset_i, .remote_reset_i, .position_o,
    .counters_o, .nv_save_o, .stamps_o, .event_o, .alarms_o, .trip_unit_stamp_o);
  task automatic check(input string n, input logic [95:0] s, input logic [95:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic note(input logic [15:0] c);
    q.push_back({c, time_stamp_i});
  endtask
  task automatic move(input logic [1:0] c, input logic [15:0] extra = 0);
    logic [2:0] n;
    int k;
    @(negedge clock_i);
    cmd <= c;
    time_stamp_i <= $urandom;
    @(negedge clock_i);
    #1 n = contacts_i;
    k = n == 3'b011 ? 0 : n == 3'b101 ? 1 : n == 3'b110 ? 2 : 3;
    if (k == 3 && !bad) note(`CODE_DISCREPANCY);
    else if (n[2] != prev[2]) note(`CODE_CONN_CHANGE);
    else if (n[1] != prev[1]) note(`CODE_DISC_CHANGE);
    else if (n != prev) note(`CODE_TEST_CHANGE);
    if (extra != 0) note(extra);
    if (k == 3) bad = 1;
    else if (n != prev) begin
      if (cnt[k] != `COUNT_MAX) cnt[k]++;
      st[k] = time_stamp_i;
    end
    prev = n;
    repeat (5) @(negedge clock_i);
    check("position", position_o, k == 3 ? POS_NONE : 4'b0010 << k);
    check("counters", counters_o, {cnt[0], cnt[1], cnt[2]});
    check("stamps", stamps_o, {st[0], st[1], st[2]});
  endtask
  task automatic pulse(ref logic s, input int n = 1);
    repeat (n) begin
      @(negedge clock_i) s = 1;
      @(negedge clock_i) s = 0;
    end
    repeat (3) @(negedge clock_i);
    check("alarms", alarms_o, ea);
  endtask
  task automatic load(input logic [15:0] v);
    move(1);
    nv_counters_i = {v, cnt[1], cnt[2]};
    cnt[0] = v;
    pulse(nv_load_i);
  endtask
  always @(posedge clock_i) begin
    if (armed && event_o.valid === 1'b1) begin
      if (q.size() == 0) check("extra event", event_o.code, 16'hFFFF);
      else check("event", {event_o.code, event_o.stamp}, q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h7dba));
    repeat (6) @(negedge clock_i);
    nrst_i = 1;
    armed = 1;
    repeat (8) @(negedge clock_i);
    check("alarms after reset", alarms_o, ea);
    pulse(local_reset_i);
    move(2);
    repeat (14) move(2'($urandom % 3));
    move(3);
    ea.discrepancy = 1;
    pulse(local_reset_i);
    move(0);
    bad = 0;
    ea.discrepancy = 0;
    pulse(remote_reset_i);
    load(16'd249);
    move(0, `CODE_SERVICE_LIFE);
    ea.service_life = 1;
    load(16'd449);
    move(0, `CODE_MAX_OPS);
    ea.max_ops = 1;
    load(16'hFFFD);
    move(0);
    move(1);
    move(0);
    no_test = 1;
    move(1);
    pulse(month_tick_i, 10);
    move(0);
    move(1);
    pulse(month_tick_i, 10);
    note(`CODE_OVERDUE);
    ea.overdue = 1;
    pulse(month_tick_i);
    pulse(local_reset_i);
    move(0);
    move(1);
    ea.overdue = 0;
    pulse(remote_reset_i);
    sn = $urandom;
    serial_i = sn;
    pulse(serial_valid_i, 2);
    serial_i = sn + 32'h0000_0001;
    note(`CODE_NEW_TRIP_UNIT);
    ea.new_trip_unit = 1;
    pulse(serial_valid_i);
    check("trip stamp", trip_unit_stamp_o, time_stamp_i);
    check("pending events", q.size(), 0);
    wrap_up;
  end
endmodule
bind cradle_position_monitor cradle_monitor_assertions u_cradle_monitor_assertions (.clock_i, .nrst_i,
  .contacts_i, .time_stamp_i, .nv_load_i, .serial_valid_i, .local_reset_i, .remote_reset_i, .position_o,
  .counters_o, .nv_save_o, .stamps_o, .event_o, .alarms_o, .trip_unit_stamp_o);
